// ==== cbi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbi_top
   import cbi_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [8:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [8:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [15:0] ENG_DONE,
   input wire logic ENG_WR,
   input wire logic [5:0] ENG_WORD,
   input wire logic [31:0] ENG_WDATA,
   output logic [31:0] ENG_RDATA,
   input wire logic ENG_ID_START,
   input wire logic [3:0] ENG_ID_SLOT,
   output logic [15:0] TIMER,
   output logic IRQ
);

   typedef struct packed {
      logic [15:0] en;
      logic [15:0] flg;
      logic [15:0] tmr;
      logic [AREA_WORDS-1:0][31:0] mem;
      logic aw_got;
      logic [8:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cbi_state_s;

   cbi_state_s s_q;
   cbi_state_s s_d;
   logic wr_fire;
   logic rd_fire;

   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : strb_mask

   // Reserved bits of a slot are never stored, so they always read as zero.
   function automatic logic [31:0] keep_mask(input logic [1:0] word);
      if (word == CTRL_WORD)
      begin
         keep_mask = CTRL_KEEP;
      end
      else if (word == IDENT_WORD)
      begin
         keep_mask = IDENT_KEEP;
      end
      else
      begin
         keep_mask = DATA_KEEP;
      end
   endfunction : keep_mask

   function automatic logic in_area(input logic [8:0] addr);
      in_area = (addr >= SLOT_BASE) && (addr < SLOT_END);
   endfunction : in_area

   function automatic logic [5:0] area_index(input logic [8:0] addr);
      area_index = 6'((addr - SLOT_BASE) >> 2);
   endfunction : area_index

   assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

   always_comb
   begin
      logic [31:0] m;
      logic [5:0] ix;
      logic [8:0] wa;
      m = strb_mask(s_q.wstrb);
      wa = {s_q.awaddr[8:2], 2'b00};
      ix = area_index(wa);
      s_d = s_q;
      s_d.tmr = s_q.tmr + 16'h0001;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = S_AXI_WDATA;
         s_d.wstrb = S_AXI_WSTRB;
      end
      if (s_q.bvalid && S_AXI_BREADY)
      begin
         s_d.bvalid = 1'b0;
      end
      if (wr_fire)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         if (wa == ENABLE_OFS)
         begin
            s_d.en = (s_q.en & ~m[15:0]) | (s_q.wdata[15:0] & m[15:0]);
         end
         else if (wa == FLAGS_OFS)
         begin
            s_d.flg = s_q.flg & ~(s_q.wdata[15:0] & m[15:0]);
         end
         else if (in_area(wa))
         begin
            // Code, format, length and identifier fields are plain storage.
            s_d.mem[ix] = (s_q.mem[ix] & ~m) | (s_q.wdata & m & keep_mask(ix[1:0]));
         end
         else
         begin
            s_d.bresp = RESP_SLVERR;
         end
      end
      // Engine writes come after the CPU's, so in a collision on one word the engine wins.
      if (ENG_WR)
      begin
         s_d.mem[ENG_WORD] = ENG_WDATA & keep_mask(ENG_WORD[1:0]);
      end
      if (ENG_ID_START)
      begin
         s_d.mem[{ENG_ID_SLOT, CTRL_WORD}][15:0] = s_q.tmr;
      end
      // Set is applied last so a completion beats a clear in the same cycle.
      s_d.flg = s_d.flg | ENG_DONE;
      if (s_q.rvalid && S_AXI_RREADY)
      begin
         s_d.rvalid = 1'b0;
      end
      if (rd_fire)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         if ({S_AXI_ARADDR[8:2], 2'b00} == ENABLE_OFS)
         begin
            s_d.rdata = {16'h0000, s_q.en};
         end
         else if ({S_AXI_ARADDR[8:2], 2'b00} == FLAGS_OFS)
         begin
            s_d.rdata = {16'h0000, s_q.flg};
         end
         else if (in_area(S_AXI_ARADDR))
         begin
            // Data byte 0 sits in bits 31..24 of the word at 0x8.
            s_d.rdata = s_q.mem[area_index({S_AXI_ARADDR[8:2], 2'b00})];
         end
         else
         begin
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         s_q <= '0;
         s_q.en <= ENABLE_RST;
         s_q.flg <= FLAGS_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign S_AXI_AWREADY = !s_q.aw_got && !s_q.bvalid;
   assign S_AXI_WREADY = !s_q.w_got && !s_q.bvalid;
   assign S_AXI_BVALID = s_q.bvalid;
   assign S_AXI_BRESP = s_q.bresp;
   assign S_AXI_ARREADY = !s_q.rvalid;
   assign S_AXI_RVALID = s_q.rvalid;
   assign S_AXI_RDATA = s_q.rdata;
   assign S_AXI_RRESP = s_q.rresp;
   assign ENG_RDATA = s_q.mem[ENG_WORD];
   assign TIMER = s_q.tmr;
   // The request is combinational on the flops so an enable write acts at once.
   assign IRQ = |(s_q.en & s_q.flg);

   logic wr_en_now;
   logic wr_flg_now;
   logic wr_bad_now;
   logic rd_en_now;
   logic rd_flg_now;
   assign wr_en_now = wr_fire && ({s_q.awaddr[8:2], 2'b00} == ENABLE_OFS);
   assign wr_flg_now = wr_fire && ({s_q.awaddr[8:2], 2'b00} == FLAGS_OFS);
   assign wr_bad_now = wr_fire && !wr_en_now && !wr_flg_now &&
      !in_area({s_q.awaddr[8:2], 2'b00});
   assign rd_en_now = rd_fire && ({S_AXI_ARADDR[8:2], 2'b00} == ENABLE_OFS);
   assign rd_flg_now = rd_fire && ({S_AXI_ARADDR[8:2], 2'b00} == FLAGS_OFS);

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   a_done_sets_flag: assert property ((ENG_DONE != 16'h0000) |=>
      ((s_q.flg & $past(ENG_DONE)) == $past(ENG_DONE)))
      else $error("completion did not set its flag");
   a_clear_loses: assert property ((wr_flg_now && ENG_DONE[0] && s_q.wdata[0]) |=>
      s_q.flg[0])
      else $error("completion lost against a clear");
   a_zero_keeps: assert property ((wr_flg_now && s_q.wdata[15:0] == 16'h0000) |=>
      ((s_q.flg & $past(s_q.flg)) == $past(s_q.flg)))
      else $error("zero write changed a flag");
   a_one_clears: assert property ((wr_flg_now && s_q.wstrb == 4'hf &&
      ENG_DONE == 16'h0000) |=> (({16'h0000, s_q.flg} & $past(s_q.wdata)) == 32'h0000_0000))
      else $error("one write did not clear a flag");
   a_masked_quiet: assert property (((s_q.en & s_q.flg) == 16'h0000) |-> !IRQ)
      else $error("interrupt without enabled flag");
   a_done_raises: assert property ((ENG_DONE[3] && s_q.en[3] && !wr_fire) |=> IRQ)
      else $error("enabled completion gave no interrupt");
   a_enable_write: assert property ((wr_en_now && s_q.wstrb[1:0] == 2'b11 &&
      (s_q.wdata[15:0] & s_q.flg) != 16'h0000) |=> IRQ)
      else $error("enable write did not raise request");
   a_stamp_taken: assert property ((ENG_ID_START && !wr_fire && !ENG_WR) |=>
      (s_q.mem[{$past(ENG_ID_SLOT), CTRL_WORD}][15:0] == $past(s_q.tmr)))
      else $error("timestamp not captured");
   a_slot_okay: assert property ((rd_fire && in_area(S_AXI_ARADDR)) |=>
      (S_AXI_RVALID && S_AXI_RRESP == RESP_OKAY))
      else $error("slot read not answered okay");
   a_resp_after_both: assert property ($rose(s_q.bvalid) |-> $past(wr_fire))
      else $error("write answered before address and data");
   // Answers must stand until taken, or a slow master would lose them.
   a_bvalid_holds: assert property ((S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID)
      else $error("write answer dropped early");
   a_bresp_holds: assert property ((S_AXI_BVALID && !S_AXI_BREADY) |=> $stable(S_AXI_BRESP))
      else $error("write response changed while waiting");
   a_rvalid_holds: assert property ((S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID)
      else $error("read answer dropped early");
   a_rdata_holds: assert property ((S_AXI_RVALID && !S_AXI_RREADY) |=> $stable(S_AXI_RDATA))
      else $error("read data changed while waiting");
   a_rresp_holds: assert property ((S_AXI_RVALID && !S_AXI_RREADY) |=> $stable(S_AXI_RRESP))
      else $error("read response changed while waiting");
   a_bvalid_drops: assert property ((S_AXI_BVALID && S_AXI_BREADY) |=> !S_AXI_BVALID)
      else $error("write answer repeated");
   a_rvalid_drops: assert property ((S_AXI_RVALID && S_AXI_RREADY) |=> !S_AXI_RVALID)
      else $error("read answer repeated");
   a_read_answer: assert property (rd_fire |=> S_AXI_RVALID)
      else $error("read not answered");
   a_write_answer: assert property (wr_fire |=> S_AXI_BVALID)
      else $error("write not answered");
   a_busy_refuses: assert property (S_AXI_BVALID |-> (!S_AXI_AWREADY && !S_AXI_WREADY))
      else $error("new write taken before answer");
   a_bad_write: assert property (wr_bad_now |=> (S_AXI_BRESP == RESP_SLVERR))
      else $error("unmapped write answered okay");
   a_timer_counts: assert property (1'b1 |=> (TIMER == 16'($past(TIMER) + 16'h0001)))
      else $error("timer did not count");
   a_enable_drop: assert property ((wr_en_now && s_q.wstrb[1:0] == 2'b11 &&
      s_q.wdata[15:0] == 16'h0000) |=> !IRQ)
      else $error("enable clear did not drop request");
   a_enable_read: assert property (rd_en_now |=>
      (S_AXI_RDATA == {16'h0000, $past(s_q.en)}))
      else $error("enable read wrong");
   a_flags_read: assert property (rd_flg_now |=>
      (S_AXI_RDATA == {16'h0000, $past(s_q.flg)}))
      else $error("flag read wrong");
   a_data_store: assert property ((ENG_WR && ENG_WORD[1:0] == DATA_LO_WORD) |=>
      (s_q.mem[$past(ENG_WORD)] == $past(ENG_WDATA)))
      else $error("engine data word not stored");
   a_ident_reserved: assert property ((ENG_WR && ENG_WORD[1:0] == IDENT_WORD) |=>
      (s_q.mem[$past(ENG_WORD)][31:29] == 3'b000))
      else $error("identifier reserved bits stored");
   a_ctrl_reserved: assert property ((ENG_WR && ENG_WORD[1:0] == CTRL_WORD) |=>
      (s_q.mem[$past(ENG_WORD)][31:28] == 4'h0 && !s_q.mem[$past(ENG_WORD)][23]))
      else $error("control reserved bits stored");
   a_irq_single: assert property ((s_q.en[0] && s_q.flg[0]) |-> IRQ)
      else $error("slot request missing from output");

endmodule : cbi_top
`default_nettype wire

// ==== cbi_pkg.sv ====
// What this block does
// - One enable bit per message slot, slot n on bit n of bits 15..0.
// - A set enable lets a slot interrupt after completion; clear enable suppresses it.
// - Writing an enable bit asserts or drops the request at once if flagged.
// - Sixteen completion flags, one per slot, in bits 15..0 of the flag register.
// - Every successful transmit or receive through a slot sets its completion flag.
// - A slot requests an interrupt while its flag and its enable are both set.
// - Writing one to a flag bit clears it; writing zero leaves it unchanged.
// - Message slot storage starts at offset 0x80 from the block base.
// - The slot area spans 256 bytes: sixteen slots of sixteen bytes each.
// - Each slot holds control word at 0x0, identifier at 0x4, eight data bytes.
// - Standard identifier in bits 28..18; extended adds bits 17..0 for 29 bits.
// - Data bytes 0..3 at 0x8, 4..7 at 0xC, lower byte most significant.
// - Control word bits 27..24 hold a slot code, written by CPU and engine.
// - Control word bits 19..16 hold data length, from engine or from software.
// - Control word bit 21 selects standard (0) or extended (1) frame format.
// - Control bits 15..0 capture the free-running timer when the identifier starts.
package cbi_pkg;
   localparam int unsigned NUM_SLOTS = 16;
   localparam int unsigned SLOT_BYTES = 16;
   localparam int unsigned SLOT_WORDS = 4;
   localparam int unsigned AREA_WORDS = NUM_SLOTS * SLOT_WORDS;
   localparam int unsigned ADDR_W = 9;
   localparam logic [8:0] ENABLE_OFS = 9'h028;
   localparam logic [8:0] FLAGS_OFS = 9'h030;
   localparam logic [8:0] SLOT_BASE = 9'h080;
   localparam logic [8:0] SLOT_END = 9'h180;
   localparam logic [1:0] CTRL_WORD = 2'h0;
   localparam logic [1:0] IDENT_WORD = 2'h1;
   localparam logic [1:0] DATA_LO_WORD = 2'h2;
   localparam logic [1:0] DATA_HI_WORD = 2'h3;
   localparam int unsigned CODE_LSB = 24;
   localparam int unsigned FORMAT_BIT = 21;
   localparam int unsigned LENGTH_LSB = 16;
   localparam int unsigned STAMP_LSB = 0;
   localparam int unsigned STD_ID_LSB = 18;
   localparam int unsigned EXT_ID_LSB = 0;
   localparam logic [31:0] CTRL_KEEP = 32'h0f7f_ffff;
   localparam logic [31:0] IDENT_KEEP = 32'h1fff_ffff;
   localparam logic [31:0] DATA_KEEP = 32'hffff_ffff;
   localparam logic [15:0] ENABLE_RST = 16'h0000;
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cbi_pkg

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top
   import cbi_pkg::*;
;
   logic clk, rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, ewr, ids, irq;
   logic [8:0] awa, ara;
   logic [31:0] wd, rdata, ewd, erd, rd;
   logic [3:0] ws, idsl;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] done, timer, ts;
   logic [5:0] ewo;
   logic [31:0] keep [4] = '{32'h0f7f_ffff, 32'h1fff_ffff, 32'hffff_ffff, 32'hffff_ffff};
   int n_errors = 0;
   int cmp_count = 0;

   cbi_top i_cbi_top (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .ENG_DONE(done),
      .ENG_WR(ewr), .ENG_WORD(ewo), .ENG_WDATA(ewd), .ENG_RDATA(erd), .ENG_ID_START(ids),
      .ENG_ID_SLOT(idsl), .TIMER(timer), .IRQ(irq));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Address and data are offered together and each is released once taken.
   // Handshakes are judged on settled values, which the design sees at the next edge.
   task automatic axw(input logic [8:0] a, input logic [31:0] d);
      logic ah;
      logic wh;
      logic bh;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do
      begin
         @(negedge clk);
         ah = awv && awr;
         wh = wv && wr;
         bh = bv && br;
         rs = bresp;
         @(posedge clk);
         if (ah) awv <= 1'b0;
         if (wh) wv <= 1'b0;
      end while (!bh);
      br <= 1'b0;
   endtask : axw

   task automatic axr(input logic [8:0] a);
      logic ah;
      logic rh;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do
      begin
         @(negedge clk);
         ah = arv && arr;
         rh = rv && rr;
         rd = rdata;
         rs = rresp;
         @(posedge clk);
         if (ah) arv <= 1'b0;
      end while (!rh);
      rr <= 1'b0;
   endtask : axr

   task automatic pulse(input logic [15:0] m);
      @(posedge clk);
      done <= m;
      @(posedge clk);
      done <= 16'h0000;
      @(posedge clk);
      #1;
   endtask : pulse

   task automatic print_verdict;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   // Sized well beyond the hundred or so cycles the sequence needs.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end

   initial
   begin
      {awv, wv, br, arv, rr, ewr, ids} = '0;
      {awa, ara, wd, ewd, ewo, idsl, done} = '0;
      ws = 4'hf;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      axr(ENABLE_OFS);
      `CHK(rd, 32'h0000_0000)
      axr(FLAGS_OFS);
      `CHK(rd, 32'h0000_0000)
      axw(ENABLE_OFS, 32'hffff_ffff);
      axr(ENABLE_OFS);
      `CHK(rd, 32'h0000_ffff)
      pulse(16'h8008);
      axr(FLAGS_OFS);
      `CHK(rd, 32'h0000_8008)
      `CHK(irq, 1'b1)
      axw(ENABLE_OFS, 32'h0000_0000);
      `CHK(irq, 1'b0)
      axw(ENABLE_OFS, 32'h0000_8000);
      `CHK(irq, 1'b1)
      axw(FLAGS_OFS, 32'h0000_0000);
      axr(FLAGS_OFS);
      `CHK(rd, 32'h0000_8008)
      axw(FLAGS_OFS, 32'h0000_8000);
      `CHK(irq, 1'b0)
      axr(FLAGS_OFS);
      `CHK(rd, 32'h0000_0008)
      // The completion is timed to land in the very cycle that the clear executes.
      fork
         axw(FLAGS_OFS, 32'h0000_0001);
         begin
            @(posedge clk);
            @(posedge clk);
            done <= 16'h0001;
            @(posedge clk);
            done <= 16'h0000;
         end
      join
      axr(FLAGS_OFS);
      `CHK(rd, 32'h0000_0009)
      for (int w = 0; w < 4; w++)
      begin
         axw(SLOT_BASE + 9'(80 + 4 * w), 32'hffff_ffff);
         axr(SLOT_BASE + 9'(80 + 4 * w));
         `CHK(rd, keep[w])
      end
      ewo <= 6'd21;
      #1;
      `CHK(erd, 32'h1fff_ffff)
      axw(9'h088, 32'h0000_0000);
      ws <= 4'b1000;
      axw(9'h088, 32'haabb_ccdd);
      ws <= 4'hf;
      ewo <= 6'd2;
      #1;
      `CHK(erd, 32'haa00_0000)
      ewo <= 6'd3;
      ewd <= 32'h4455_6677;
      ewr <= 1'b1;
      @(posedge clk);
      ewr <= 1'b0;
      axr(9'h08c);
      `CHK(rd, 32'h4455_6677)
      axw(9'h17c, 32'h1234_5678);
      `CHK(rs, RESP_OKAY)
      axr(9'h17c);
      `CHK(rd, 32'h1234_5678)
      axr(9'h180);
      `CHK(rs, RESP_SLVERR)
      axw(9'h180, 32'h0000_0000);
      `CHK(rs, RESP_SLVERR)
      axr(9'h07c);
      `CHK(rs, RESP_SLVERR)
      @(posedge clk);
      idsl <= 4'd2;
      ids <= 1'b1;
      @(negedge clk);
      ts = timer;
      @(posedge clk);
      ids <= 1'b0;
      axr(9'h0a0);
      `CHK(rd[15:0], ts)
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
